/* File: hdl/isc_status_control_regs.sv */
// Purpose: Status, identification and control register bank of the instrument.
// Assumes: One 40 MHz clock; frame handler issues one-cycle read or write requests.
// Notes: Keys and the digital input pin are resynchronised; the rest is on-clock logic.
`timescale 1ns/100ps
`default_nettype none
module isc_status_control_regs #(
  parameter int          ERR_W     = 16,
  parameter logic [7:0]  FW_VER    = 8'h15,
  parameter logic [7:0]  FW_SUBVER = 8'h00,
  parameter logic [7:0]  DEVICE_ID = 8'h5a
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire isc_pkg::isc_req_s  regReq,
  output var  isc_pkg::isc_rsp_s  regRsp,
  input  wire logic               strapBus,
  input  wire logic               strapSysDev,
  input  wire logic               strapOpt1,
  input  wire logic               strapOpt2,
  input  wire logic [2:0]         strapOutPresent,
  input  wire logic               strapOut3Analog,
  input  wire logic               digitalInputOnePin,
  input  wire logic [2:0]         keyPin,
  input  wire logic [5:0]         analogFault,
  input  wire logic [15:0]        alarmPending,
  input  wire logic [5:0]         digitalOutState,
  input  wire logic               measStrobe,
  input  wire logic [ERR_W-1:0]   errCause,
  input  wire logic               panelAdjReq,
  output logic                    panelAdjGrant,
  output logic                    panelAdjBlocked,
  output logic                    remoteLock,
  output logic                    minClear,
  output logic                    maxClear,
  output logic [ERR_W-1:0]        errList,
  output logic                    digitalInputOne
);
  import isc_pkg::*;

  function automatic logic isBinary(input logic [15:0] v);
    isBinary = (v[15:1] == 15'h0000);
  endfunction

  function automatic logic isMapped(input logic [15:0] a);
    case (a)
      OFS_AIN_FAULT, OFS_ALARM, OFS_DO_STAT, OFS_DI_STAT,
      OFS_FORCING, OFS_REMOTE, OFS_ERR_CLR, OFS_MIN_CLR,
      OFS_MAX_CLR, OFS_HARDWARE_OPTIONS, OFS_FW_VER, OFS_OP_VER,
      OFS_DEV_ID, OFS_FW_SUB: isMapped = 1'b1;
      default:                isMapped = 1'b0;
    endcase
  endfunction

  // Pin synchroniser: bit 0 is the digital input, bits 3:1 the front keys.
  logic [3:0] pinS1;
  logic [3:0] pinS2;
  logic [3:0] pinS3;
  logic [3:0] pinFilt;
  logic [3:0] next_pinFilt;

  always_comb begin
    next_pinFilt = pinFilt;
    for (int i = 0; i < 4; i++) begin
      if (pinS2[i] == pinS3[i]) begin
        next_pinFilt[i] = pinS3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pinS1   <= 4'h0;
      pinS2   <= 4'h0;
      pinS3   <= 4'h0;
      pinFilt <= 4'h0;
    end else begin
      pinS1   <= {keyPin, digitalInputOnePin};
      pinS2   <= pinS1;
      pinS3   <= pinS2;
      pinFilt <= next_pinFilt;
    end
  end

  // Straps are static, so they are sampled while reset is held.
  logic [15:0] hwOptions;
  logic [15:0] next_hwOptions;

  always_comb begin
    next_hwOptions                           = 16'h0000;
    next_hwOptions[HW_OUT1]                  = strapOutPresent[0];
    next_hwOptions[HW_OUT2]                  = strapOutPresent[1];
    next_hwOptions[HW_OUT3]                  = strapOutPresent[2];
    next_hwOptions[HW_OUT3AN]                = strapOut3Analog;
    next_hwOptions[HW_BUS]                   = strapBus;
    next_hwOptions[HW_SYSDEV]                = strapSysDev;
    next_hwOptions[HW_OPT1]                  = strapOpt1;
    next_hwOptions[HW_OPT2]                  = strapOpt2;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hwOptions <= next_hwOptions;
    end
  end

  // Control and status state.
  logic [15:0]      forcing;
  logic [15:0]      next_forcing;
  logic             next_remoteLock;
  logic             next_minClear;
  logic             next_maxClear;
  logic [ERR_W-1:0] next_errList;
  logic             next_digitalInputOne;
  logic             next_panelAdjGrant;
  logic             next_panelAdjBlocked;
  isc_rsp_s         next_regRsp;
  logic [15:0]      statusDi;
  logic [15:0]      statusAin;
  logic [15:0]      statusDo;
  logic             wrErr;
  logic             wrMin;
  logic             wrMax;
  logic             wrOk;

  always_comb begin
    statusDi                         = 16'h0000;
    statusDi[DI_ONE_BIT]             = digitalInputOne;
    statusDi[KEY_LSB +: 3]           = pinFilt[3:1];
    statusDi                         = statusDi & MASK_DI;
    statusAin                        = {9'h000, analogFault[5:3], 1'b0, analogFault[2:0]} & MASK_AIN;
    statusDo                         = {10'h000, digitalOutState} & MASK_DO;
  end

  always_comb begin
    next_forcing         = forcing;
    next_remoteLock      = remoteLock;
    next_errList         = errList;
    next_regRsp          = '0;
    wrOk                 = 1'b0;
    wrErr                = 1'b0;
    wrMin                = 1'b0;
    wrMax                = 1'b0;

    if (regReq.write) begin
      next_regRsp.ack = 1'b1;
      case (regReq.addr)
        OFS_FORCING: begin
          wrOk         = 1'b1;
          next_forcing = regReq.data;
        end
        OFS_REMOTE: begin
          wrOk = isBinary(regReq.data);
          if (wrOk) begin
            next_remoteLock = regReq.data[0];
          end
        end
        OFS_ERR_CLR: begin
          wrOk  = isBinary(regReq.data);
          wrErr = wrOk && regReq.data[0];
        end
        OFS_MIN_CLR: begin
          wrOk  = isBinary(regReq.data);
          wrMin = wrOk && regReq.data[0];
        end
        OFS_MAX_CLR: begin
          wrOk  = isBinary(regReq.data);
          wrMax = wrOk && regReq.data[0];
        end
        default: begin
          wrOk = 1'b0;
        end
      endcase
      next_regRsp.error = ~wrOk;
    end else if (regReq.read) begin
      next_regRsp.ack   = 1'b1;
      next_regRsp.error = ~isMapped(regReq.addr);
      case (regReq.addr)
        OFS_AIN_FAULT: next_regRsp.data = statusAin;
        OFS_ALARM:     next_regRsp.data = alarmPending & MASK_ALARM;
        OFS_DO_STAT:   next_regRsp.data = statusDo;
        OFS_DI_STAT:   next_regRsp.data = statusDi;
        OFS_FORCING:   next_regRsp.data = forcing;
        OFS_REMOTE:    next_regRsp.data = {15'h0000, remoteLock};
        OFS_HARDWARE_OPTIONS:    next_regRsp.data = hwOptions;
        OFS_FW_VER:    next_regRsp.data = {8'h00, FW_VER};
        OFS_OP_VER:    next_regRsp.data = {8'h00, FW_VER};
        OFS_DEV_ID:    next_regRsp.data = {8'h00, DEVICE_ID};
        OFS_FW_SUB:    next_regRsp.data = {8'h00, FW_SUBVER};
        default:       next_regRsp.data = RST_WORD;
      endcase
    end

    // A measurement in the same cycle as a clear re-enters live causes, so no event is lost.
    if (wrErr) begin
      next_errList = {ERR_W{1'b0}};
    end
    if (measStrobe) begin
      next_errList = next_errList | errCause;
    end

    next_minClear        = wrMin;
    next_maxClear        = wrMax;
    // Forcing bit DI_ONE_BIT is OR-linked onto the pin so a master can only raise the input.
    next_digitalInputOne = pinFilt[0] | forcing[DI_ONE_BIT];
    next_panelAdjGrant   = panelAdjReq & ~remoteLock;
    next_panelAdjBlocked = panelAdjReq & remoteLock;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      forcing         <= RST_WORD;
      remoteLock      <= 1'b0;
      errList         <= {ERR_W{1'b0}};
      minClear        <= 1'b0;
      maxClear        <= 1'b0;
      digitalInputOne <= 1'b0;
      panelAdjGrant   <= 1'b0;
      panelAdjBlocked <= 1'b0;
      regRsp          <= '0;
    end else begin
      forcing         <= next_forcing;
      remoteLock      <= next_remoteLock;
      errList         <= next_errList;
      minClear        <= next_minClear;
      maxClear        <= next_maxClear;
      digitalInputOne <= next_digitalInputOne;
      panelAdjGrant   <= next_panelAdjGrant;
      panelAdjBlocked <= next_panelAdjBlocked;
      regRsp          <= next_regRsp;
    end
  end

endmodule
`default_nettype wire

/* File: hdl/isc_pkg.sv */
// Purpose: Constants and carriers for the instrument status and control register bank.
// Assumes: 16-bit words reached by register index from the fieldbus frame handler.
// Notes: Offsets are register indices, not byte addresses.
package isc_pkg;

  localparam logic [15:0] OFS_AIN_FAULT = 16'h0016;
  localparam logic [15:0] OFS_ALARM     = 16'h0017;
  localparam logic [15:0] OFS_DO_STAT   = 16'h0018;
  localparam logic [15:0] OFS_DI_STAT   = 16'h0019;
  localparam logic [15:0] OFS_FORCING   = 16'h001c;
  localparam logic [15:0] OFS_REMOTE    = 16'h0037;
  localparam logic [15:0] OFS_ERR_CLR   = 16'h003f;
  localparam logic [15:0] OFS_MIN_CLR   = 16'h0041;
  localparam logic [15:0] OFS_MAX_CLR   = 16'h0042;
  localparam logic [15:0] OFS_HARDWARE_OPTIONS    = 16'h00c8;
  localparam logic [15:0] OFS_FW_VER    = 16'h00c9;
  localparam logic [15:0] OFS_OP_VER    = 16'h00ca;
  localparam logic [15:0] OFS_DEV_ID    = 16'h00cb;
  localparam logic [15:0] OFS_FW_SUB    = 16'h00cc;

  localparam int HW_OUT1   = 0;
  localparam int HW_OUT2   = 1;
  localparam int HW_OUT3   = 2;
  localparam int HW_OUT3AN = 3;
  localparam int HW_BUS    = 8;
  localparam int HW_SYSDEV = 9;
  localparam int HW_OPT1   = 10;
  localparam int HW_OPT2   = 11;

  localparam int DI_ONE_BIT = 0;
  localparam int KEY_LSB    = 8;

  localparam logic [15:0] MASK_AIN   = 16'h0077;
  localparam logic [15:0] MASK_ALARM = 16'h0307;
  localparam logic [15:0] MASK_DO    = 16'h003f;
  localparam logic [15:0] MASK_DI    = 16'h0701;

  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [15:0] addr;
    logic [15:0] data;
  } isc_req_s;

  typedef struct packed {
    logic        ack;
    logic        error;
    logic [15:0] data;
  } isc_rsp_s;

endpackage

/* File: sim/isc_regs_properties.sv */
// Purpose: Port checker for the status and control register bank.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every instance of the bank.
`timescale 1ns/100ps
`default_nettype none
module isc_regs_properties #(
  parameter int ERR_W = 16
) (
  input wire logic              clk,
  input wire logic              rst,
  input wire isc_pkg::isc_req_s regReq,
  input wire isc_pkg::isc_rsp_s regRsp,
  input wire logic              measStrobe,
  input wire logic [ERR_W-1:0]  errCause,
  input wire logic              panelAdjReq,
  input wire logic              panelAdjGrant,
  input wire logic              panelAdjBlocked,
  input wire logic              remoteLock,
  input wire logic              minClear,
  input wire logic              maxClear,
  input wire logic [ERR_W-1:0]  errList
);
  import isc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic anyReq = regReq.write || regReq.read;
  wire logic wrOne = regReq.write && regReq.data == 16'h0001;
  wire logic errClr = wrOne && regReq.addr == OFS_ERR_CLR;
  sequence one_pulse(s);
    s ##1 !s;
  endsequence
  ack_timing_a: assert property (anyReq |=> regRsp.ack) else $error("ack missing");
  ack_idle_a: assert property (!anyReq |=> !regRsp.ack) else $error("stray ack");
  lock_block_a: assert property (panelAdjReq && remoteLock |=> panelAdjBlocked && !panelAdjGrant)
    else $error("panel not blocked");
  lock_grant_a: assert property (panelAdjReq && !remoteLock |=> panelAdjGrant && !panelAdjBlocked)
    else $error("panel not granted");
  min_clear_a: assert property (wrOne && regReq.addr == OFS_MIN_CLR |=> one_pulse(minClear))
    else $error("min clear pulse wrong");
  max_clear_a: assert property (wrOne && regReq.addr == OFS_MAX_CLR |=> one_pulse(maxClear))
    else $error("max clear pulse wrong");
  zero_clear_a: assert property (regReq.write && regReq.data == 16'h0000 |=> !minClear && !maxClear)
    else $error("zero write cleared");
  ro_write_a: assert property (regReq.write && regReq.addr >= OFS_HARDWARE_OPTIONS && regReq.addr <= OFS_FW_SUB
    |=> regRsp.error) else $error("read-only write accepted");
  err_keep_a: assert property (measStrobe && !errClr |=> (errList & $past(errCause)) == $past(errCause))
    else $error("error not kept");
  err_clear_a: assert property (errClr |=> errList == ($past(measStrobe) ? $past(errCause) : '0))
    else $error("error list clear wrong");
endmodule
bind isc_status_control_regs isc_regs_properties #(.ERR_W(ERR_W)) i_isc_regs_properties (.clk(clk), .rst(rst),
  .regReq(regReq), .regRsp(regRsp), .measStrobe(measStrobe), .errCause(errCause), .panelAdjReq(panelAdjReq),
  .panelAdjGrant(panelAdjGrant), .panelAdjBlocked(panelAdjBlocked), .remoteLock(remoteLock),
  .minClear(minClear), .maxClear(maxClear), .errList(errList));
`default_nettype wire

/* File: sim/isc_master_model.sv */
// Purpose: Bus master model issuing one-word register requests.
// Assumes: Requests change at the falling edge.
// Notes: Released address and data lines carry the inverse so a stale word never looks valid.
`timescale 1ns/100ps
`default_nettype none
module isc_master_model (
  input  wire logic              clk,
  output var  isc_pkg::isc_req_s req,
  input  wire isc_pkg::isc_rsp_s rsp
);
  import isc_pkg::*;
  initial req = '0;
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d, output isc_rsp_s r);
    @(negedge clk);
    req = '{write: w, read: !w, addr: a, data: d};
    @(negedge clk);
    // The answer stands for one cycle only, so it is taken before the request is released.
    r = rsp;
    req = '{write: 1'b0, read: 1'b0, addr: ~a, data: ~d};
  endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the status and control register bank.
// Assumes: 40 MHz clock, inputs driven at the falling edge.
// Notes: Pins settle through the input filter before status is read.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin errors++; $display("Error %s exp %0h got %0h", n, e, s); end end
module tb;
  import isc_pkg::*;
  localparam logic [7:0] FW  = 8'h15;
  localparam logic [7:0] SUB = 8'h03;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        pin = 1'b0;
  logic        ms  = 1'b0;
  logic        pr  = 1'b0;
  logic [7:0]  st  = 8'h6d;
  logic [2:0]  key = 3'h0;
  logic [5:0]  af  = 6'h00;
  logic [5:0]  dout = 6'h00;
  logic [15:0] al  = 16'h0000;
  logic [15:0] ec  = 16'h0000;
  isc_req_s    req;
  isc_rsp_s    rsp;
  isc_rsp_s    r;
  wire logic   pg, pb, lock, mnc, mxc, dIn;
  wire logic [15:0] el;
  int          errors = 0;
  int          cmp_count = 0;
  logic [15:0] clr [3] = '{OFS_MIN_CLR, OFS_MAX_CLR, OFS_ERR_CLR};
  always #12.5 clk = ~clk;
  isc_status_control_regs #(.FW_VER(FW), .FW_SUBVER(SUB), .DEVICE_ID(8'h3c)) i_isc_status_control_regs (
    .clk(clk), .rst(rst), .regReq(req), .regRsp(rsp), .strapBus(st[0]), .strapSysDev(st[1]),
    .strapOpt1(st[2]), .strapOpt2(st[3]), .strapOutPresent(st[6:4]), .strapOut3Analog(st[7]),
    .digitalInputOnePin(pin), .keyPin(key), .analogFault(af), .alarmPending(al), .digitalOutState(dout),
    .measStrobe(ms), .errCause(ec), .panelAdjReq(pr), .panelAdjGrant(pg), .panelAdjBlocked(pb),
    .remoteLock(lock), .minClear(mnc), .maxClear(mxc), .errList(el), .digitalInputOne(dIn));
  isc_master_model i_isc_master_model (.clk(clk), .req(req), .rsp(rsp));
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    i_isc_master_model.xfer(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [15:0] a);
    i_isc_master_model.xfer(1'b0, a, 16'h0000, r);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic test_done;
    $display("Compares %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    tick(20);
    rst = 1'b0;
    rd(OFS_HARDWARE_OPTIONS); `CHK("hwopt", {4'h0, st[3:0], 4'h0, st[7:4]}, r.data);
    `CHK("ack", 2'h2, {r.ack, r.error});
    wr(OFS_HARDWARE_OPTIONS, 16'h0000); `CHK("ro write", 1'b1, r.error);
    rd(OFS_FW_VER); `CHK("fw", {8'h00, FW}, r.data);
    rd(OFS_OP_VER); `CHK("opver", {8'h00, FW}, r.data);
    rd(OFS_FW_SUB); `CHK("sub", {8'h00, SUB}, r.data);
    rd(16'h0000); `CHK("unmapped", 17'h10000, {r.error, r.data});
    af = 6'h2d;
    al = 16'hffff;
    dout = 6'h2a;
    key = 3'h5;
    pin = 1'b1;
    tick(8);
    rd(OFS_AIN_FAULT); `CHK("ain", {9'h000, af[5:3], 1'b0, af[2:0]}, r.data);
    rd(OFS_ALARM); `CHK("alarm", MASK_ALARM, r.data);
    rd(OFS_DO_STAT); `CHK("dout", {10'h000, dout}, r.data);
    rd(OFS_DI_STAT); `CHK("di", {5'h00, key, 8'h01}, r.data);
    pin = 1'b0;
    wr(OFS_FORCING, 16'h0001);
    tick(8); `CHK("forced", 1'b1, dIn);
    rd(OFS_FORCING); `CHK("force rb", 16'h0001, r.data);
    wr(OFS_FORCING, 16'h0000);
    tick(8); `CHK("released", 1'b0, dIn);
    wr(OFS_REMOTE, 16'h0001); `CHK("lock", 1'b1, lock);
    pulse(pr); `CHK("blocked", 2'h1, {pg, pb});
    wr(OFS_REMOTE, 16'h0002); `CHK("lock bad", 2'h3, {r.error, lock});
    wr(OFS_REMOTE, 16'h0000);
    pulse(pr); `CHK("unlock", 1'b0, lock);
    `CHK("granted", 2'h2, {pg, pb});
    ec = 16'h0005;
    pulse(ms);
    ec = 16'h0100;
    pulse(ms); `CHK("errlist", 16'h0105, el);
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 3; j++) begin
        wr(clr[i], 16'(j)); `CHK("clr err", (j > 1), r.error);
        `CHK("min", (i == 0 && j == 1), mnc);
        `CHK("max", (i == 1 && j == 1), mxc);
      end
    end
    `CHK("cleared", 16'h0000, el);
    pulse(ms); `CHK("reentry", 16'h0100, el);
    test_done;
  end
  // The run needs about a hundred cycles, so this span only trips on a hang.
  initial begin
    tick(5000);
    errors++;
    test_done;
  end
endmodule
`default_nettype wire
